// ---- hw/aux_params.svh ----
`ifndef AUX_PARAMS_SVH
`define AUX_PARAMS_SVH
// ==========================================
// Register byte offsets
`define OFS_SETUP_MISC 8'h00
`define OFS_EXC_SOURCE 8'h04
`define OFS_BRIDGE_SW 8'h08
`define OFS_PIN_FUNC 8'h0C
`define OFS_PIN_VALUE 8'h10
`define OFS_BIAS 8'h14
`define OFS_STATUS 8'h18
`define OFS_RESULT 8'h1C
// ==========================================
// Field positions
`define F_BIPOLAR 0
`define F_CHOP_LO 1
`define F_CHOP_HI 2
`define F_EXC_SWAP 3
`define F_REF_EN 4
`define F_EXC_PIN_A_LO 0
`define F_EXC_MAG_A_LO 4
`define F_EXC_PIN_B_LO 8
`define F_EXC_MAG_B_LO 12
`define F_SW_FUNC_LO 0
`define F_SW_CTRL_LO 2
`define F_SW_KEEP_LO 4
`define F_CHAN_OUT_EN 4
// ==========================================
// Codes and reset values
`define CHOP_ENABLE_CODE 2'b01
`define MSB_FLIP 24'h800000
`define RST_SETUP_MISC 5'h10
`define RST_BIAS 9'h000
`define EXC_MAG_OFF 3'h0
`endif

// ---- hw/aux_pkg.sv ----
package aux_pkg;
  // Current source magnitudes; code 0 leaves the source off
  typedef enum logic [2:0] {
    EXC_OFF = 3'h0,
    EXC_10UA = 3'h1,
    EXC_50UA = 3'h2,
    EXC_100UA = 3'h3,
    EXC_250UA = 3'h4,
    EXC_500UA = 3'h5,
    EXC_1MA = 3'h6,
    EXC_1MA5 = 3'h7
  } exc_magnitude_t;

  typedef logic signed [23:0] code_t;
  typedef logic [3:0] pin_sel_t;

  typedef enum logic [2:0] {
    AVG_IDLE = 3'b001,
    AVG_HALF = 3'b010,
    AVG_PAIR = 3'b100
  } avg_state_t;
endpackage : aux_pkg

// ---- hw/aux_avg_if.sv ----
`timescale 1ns/100ps
interface aux_avg_if;
  logic in_valid;
  aux_pkg::code_t in_val;
  logic in_phase;
  logic chop_on;
  logic swap_on;
  logic restart;
  logic out_valid;
  aux_pkg::code_t out_val;
  logic have_prev;

  modport avg (input in_valid, in_val, in_phase, chop_on, swap_on, restart,
    output out_valid, out_val, have_prev);
  modport ctl (output in_valid, in_val, in_phase, chop_on, swap_on, restart,
    input out_valid, out_val, have_prev);
endinterface : aux_avg_if

// ---- hw/chop_avg.sv ----
`timescale 1ns/100ps
module chop_avg (
  input wire logic ref_clk, // Core clock
  input wire logic sys_rst, // Async reset, high
  aux_avg_if.avg av // Sample and result channel
);
  import aux_pkg::*;

  typedef struct packed {
    avg_state_t st;
    code_t prev;
    logic out_valid;
    code_t out_val;
  } avg_reg_t;

  avg_reg_t s_q, s_d;

  // Mean of two at full precision, rounded half up, clamped to 24 bits
  function automatic code_t half_round(input logic signed [25:0] sum);
    logic signed [25:0] r;
    r = (sum + 26'sd1) >>> 1;
    if (r > 26'sh07FFFFF) begin
      half_round = 24'sh7FFFFF;
    end else begin
      half_round = r[23:0];
    end
  endfunction : half_round

  always_comb begin
    logic signed [25:0] a;
    logic signed [25:0] b;
    a = 26'(av.in_val);
    b = 26'(s_q.prev);
    s_d = s_q;
    s_d.out_valid = 1'b0;
    if (av.restart) begin
      s_d.st = AVG_IDLE;
    end else if (av.in_valid) begin
      s_d.prev = av.in_val;
      case (s_q.st)
        AVG_IDLE: begin
          if (av.chop_on || av.swap_on) begin
            s_d.st = AVG_HALF;
          end else begin
            s_d.out_valid = 1'b1;
            s_d.out_val = av.in_val;
          end
        end
        AVG_HALF, AVG_PAIR: begin
          s_d.st = AVG_PAIR;
          s_d.out_valid = 1'b1;
          if (av.chop_on) begin
            // Inverted sample carries minus the signal, same offset
            s_d.out_val = av.in_phase ? half_round(b - a) : half_round(a - b); // RULE_17 RULE_21
          end else begin
            s_d.out_val = half_round(a + b); // RULE_06 RULE_21
          end
        end
        default: begin
          s_d.st = AVG_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '{st: AVG_IDLE, prev: 24'sh000000, out_valid: 1'b0, out_val: 24'sh000000};
    end else begin
      s_q <= s_d;
    end
  end

  assign av.out_valid = s_q.out_valid;
  assign av.out_val = s_q.out_val;
  assign av.have_prev = (s_q.st != AVG_IDLE);
endmodule : chop_avg

// ---- hw/aux_pin_and_chop_control.sv ----
`timescale 1ns/100ps
`include "aux_params.svh"
// Functional notes
// (RULE_01) Unipolar results come out as straight binary
// (RULE_02) Bipolar results come out as twos complement
// (RULE_03) Two current sources, seven magnitudes each
// (RULE_04) Separate pin and magnitude field per source
// (RULE_05) Both sources may share one pin
// (RULE_06) Swap sources each conversion, average pairs
// (RULE_07) Software enables reference when sources used
// (RULE_08) Pins 0 and 1 act as bridge switches
// (RULE_09) Standby opens switches unless keep bit set
// (RULE_10) Each pin individually input or output
// (RULE_11) Output pin drives its stored value bit
// (RULE_12) Value read returns sampled pin levels
// (RULE_13) Priority: switch, then output data, then channel
// (RULE_14) Channel bits drive pins left unclaimed
// (RULE_15) Per-input bias generator enable bits
// (RULE_16) Chop on only for code 01
// (RULE_17) Chop alternates polarity, averages opposite pairs
// (RULE_18) First chop result double settle, then single
// (RULE_19) Sinc3 chop: third rate, double settling
// (RULE_20) Pins follow active channel in step
// (RULE_21) Average is full-precision mean rounded
module aux_pin_and_chop_control (
  input wire logic ref_clk, // Core clock, 25 MHz
  input wire logic sys_rst, // Async reset, high
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction, high write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire logic conv_done, // Core result pulse
  input wire logic [23:0] conv_raw, // Core result, offset binary
  input wire logic sinc3_sel, // Core runs sinc3 filter
  input wire logic standby, // Core is in standby
  input wire logic [3:0] seq_channel, // Sequencer active channel
  output logic in_swap, // Analog input polarity inverted
  output logic settle_double, // Next conversion needs two settles
  output logic rate_third, // Sinc3 chop rate reduction
  output logic data_valid, // Formatted result pulse
  output logic [23:0] data_code, // Formatted result
  output logic [3:0] exc_pin_a, // Source A pin select
  output aux_pkg::exc_magnitude_t exc_mag_a, // Source A magnitude
  output logic [3:0] exc_pin_b, // Source B pin select
  output aux_pkg::exc_magnitude_t exc_mag_b, // Source B magnitude
  output logic ref_en, // On-chip reference enable
  output logic [1:0] bridge_switch_closed, // Switch a/b closed
  output logic [8:0] bias_input_enable, // Bias per analog input
  input wire logic [3:0] gpio_in, // Pin levels, asynchronous
  output logic [3:0] gpio_out, // Pin drive levels
  output logic [3:0] gpio_oe_n // Pin drive enable, low drives
);
  import aux_pkg::*;

  // ==========================================
  // State
  typedef struct packed {
    logic bipolar;
    logic [1:0] chop_field;
    logic exc_swap_enable;
    logic ref_en;
    pin_sel_t pin_a;
    exc_magnitude_t mag_a;
    pin_sel_t pin_b;
    exc_magnitude_t mag_b;
    logic [1:0] sw_func;
    logic [1:0] bridge_switch_ctrl;
    logic [1:0] switch_keep_in_standby;
    logic [3:0] pin_mode;
    logic channel_number_out_en;
    logic [3:0] pin_value_bit;
    logic [8:0] bias;
    logic [3:0] sync_a;
    logic [3:0] sync_b;
    logic [31:0] rdata;
    logic phase;
    logic first_pending;
    logic [23:0] code;
    logic code_seen;
    logic valid_pulse;
    logic [3:0] pin_out;
    logic [3:0] pin_oe_n;
    logic [1:0] sw_closed;
    logic [3:0] exc_a_pin;
    exc_magnitude_t exc_a_mag;
    logic [3:0] exc_b_pin;
    exc_magnitude_t exc_b_mag;
  } ctl_state_t;

  ctl_state_t s_q, s_d;
  aux_avg_if av ();

  logic chop_on;
  logic swap_on;
  logic mapped;
  logic wr_en;

  // Setup word reset value, split into its fields at reset
  localparam logic [4:0] RST_MISC = `RST_SETUP_MISC;

  // ==========================================
  // Helpers
  function automatic logic addr_known(input logic [7:0] a);
    case (a)
      `OFS_SETUP_MISC, `OFS_EXC_SOURCE, `OFS_BRIDGE_SW, `OFS_PIN_FUNC,
      `OFS_PIN_VALUE, `OFS_BIAS, `OFS_STATUS, `OFS_RESULT: begin
        addr_known = 1'b1;
      end
      default: begin
        addr_known = 1'b0;
      end
    endcase
  endfunction : addr_known

  // Sign domain flips the top bit both ways
  function automatic logic [23:0] flip_msb(input logic [23:0] v);
    flip_msb = v ^ `MSB_FLIP;
  endfunction : flip_msb

  assign chop_on = (s_q.chop_field == `CHOP_ENABLE_CODE); // RULE_16
  assign swap_on = s_q.exc_swap_enable;
  assign mapped = addr_known(paddr);
  assign wr_en = psel && penable && pwrite && mapped;

  // ==========================================
  // Averager
  assign av.in_valid = conv_done;
  assign av.in_val = code_t'(flip_msb(conv_raw));
  assign av.in_phase = s_q.phase;
  assign av.chop_on = chop_on;
  assign av.swap_on = swap_on;
  // Mode change drops a half-formed pair, so no mixed average escapes
  assign av.restart = wr_en && (paddr == `OFS_SETUP_MISC) &&
    ((pwdata[`F_CHOP_HI:`F_CHOP_LO] != s_q.chop_field) ||
    (pwdata[`F_EXC_SWAP] != s_q.exc_swap_enable));

  chop_avg u_avg (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .av(av)
  );

  // ==========================================
  // Next state
  always_comb begin
    logic [31:0] rd;
    logic [3:0] drv;
    logic [3:0] lvl;
    logic [3:0] claim;
    rd = 32'h00000000;
    drv = 4'h0;
    lvl = 4'h0;
    // Only pins 0 and 1 can carry a bridge switch
    claim = {2'b00, s_q.sw_func};
    s_d = s_q;
    s_d.valid_pulse = 1'b0;

    // Pin levels pass two stages before anyone looks
    s_d.sync_a = gpio_in;
    s_d.sync_b = s_q.sync_a;

    if (wr_en) begin
      case (paddr)
        `OFS_SETUP_MISC: begin
          s_d.bipolar = pwdata[`F_BIPOLAR];
          s_d.chop_field = pwdata[`F_CHOP_HI:`F_CHOP_LO];
          s_d.exc_swap_enable = pwdata[`F_EXC_SWAP];
          s_d.ref_en = pwdata[`F_REF_EN];
        end
        `OFS_EXC_SOURCE: begin
          s_d.pin_a = pwdata[`F_EXC_PIN_A_LO +: 4]; // RULE_04
          s_d.mag_a = exc_magnitude_t'(pwdata[`F_EXC_MAG_A_LO +: 3]); // RULE_03
          s_d.pin_b = pwdata[`F_EXC_PIN_B_LO +: 4]; // RULE_04
          s_d.mag_b = exc_magnitude_t'(pwdata[`F_EXC_MAG_B_LO +: 3]); // RULE_03
        end
        `OFS_BRIDGE_SW: begin
          s_d.sw_func = pwdata[`F_SW_FUNC_LO +: 2];
          s_d.bridge_switch_ctrl = pwdata[`F_SW_CTRL_LO +: 2];
          s_d.switch_keep_in_standby = pwdata[`F_SW_KEEP_LO +: 2];
        end
        `OFS_PIN_FUNC: begin
          s_d.pin_mode = pwdata[3:0]; // RULE_10
          s_d.channel_number_out_en = pwdata[`F_CHAN_OUT_EN];
        end
        `OFS_PIN_VALUE: begin
          s_d.pin_value_bit = pwdata[3:0];
        end
        `OFS_BIAS: begin
          s_d.bias = pwdata[8:0]; // RULE_15
        end
        default: begin
        end
      endcase
    end

    // Polarity and source swap advance once per conversion
    if (av.restart) begin
      s_d.phase = 1'b0;
      s_d.first_pending = 1'b1;
    end else if (conv_done) begin
      s_d.phase = (chop_on || swap_on) ? !s_q.phase : 1'b0; // RULE_06 RULE_17
      s_d.first_pending = 1'b0;
    end

    if (av.out_valid) begin
      // Averager works signed; unipolar goes back to straight binary
      s_d.code = s_q.bipolar ? 24'(av.out_val) : flip_msb(24'(av.out_val)); // RULE_01 RULE_02
      s_d.code_seen = 1'b1;
      s_d.valid_pulse = 1'b1;
    end

    // Sources may land on one pin; no exclusion is applied
    if (swap_on && s_q.phase) begin
      s_d.exc_a_pin = s_q.pin_b; // RULE_06
      s_d.exc_b_pin = s_q.pin_a; // RULE_06
    end else begin
      s_d.exc_a_pin = s_q.pin_a; // RULE_05
      s_d.exc_b_pin = s_q.pin_b; // RULE_05
    end
    s_d.exc_a_mag = s_q.mag_a;
    s_d.exc_b_mag = s_q.mag_b;

    // Switch state drops in standby unless kept
    s_d.sw_closed = s_q.sw_func & s_q.bridge_switch_ctrl &
      (standby ? s_q.switch_keep_in_standby : 2'b11); // RULE_08 RULE_09

    // Pin ownership, highest priority first
    for (int i = 0; i < 4; i++) begin
      if (claim[i]) begin
        drv[i] = 1'b0; // RULE_13
        lvl[i] = 1'b0;
      end else if (s_q.pin_mode[i]) begin
        drv[i] = 1'b1; // RULE_13
        lvl[i] = s_q.pin_value_bit[i]; // RULE_11
      end else if (s_q.channel_number_out_en) begin
        drv[i] = 1'b1; // RULE_14
        lvl[i] = seq_channel[i]; // RULE_20
      end else begin
        drv[i] = 1'b0;
        lvl[i] = 1'b0;
      end
    end
    s_d.pin_out = lvl;
    s_d.pin_oe_n = ~drv;

    // Read data sampled in setup, held through access
    case (paddr)
      `OFS_SETUP_MISC: begin
        rd[`F_BIPOLAR] = s_q.bipolar;
        rd[`F_CHOP_HI:`F_CHOP_LO] = s_q.chop_field;
        rd[`F_EXC_SWAP] = s_q.exc_swap_enable;
        rd[`F_REF_EN] = s_q.ref_en;
      end
      `OFS_EXC_SOURCE: begin
        rd[`F_EXC_PIN_A_LO +: 4] = s_q.pin_a;
        rd[`F_EXC_MAG_A_LO +: 3] = s_q.mag_a;
        rd[`F_EXC_PIN_B_LO +: 4] = s_q.pin_b;
        rd[`F_EXC_MAG_B_LO +: 3] = s_q.mag_b;
      end
      `OFS_BRIDGE_SW: begin
        rd[`F_SW_FUNC_LO +: 2] = s_q.sw_func;
        rd[`F_SW_CTRL_LO +: 2] = s_q.bridge_switch_ctrl;
        rd[`F_SW_KEEP_LO +: 2] = s_q.switch_keep_in_standby;
      end
      `OFS_PIN_FUNC: begin
        rd[3:0] = s_q.pin_mode;
        rd[`F_CHAN_OUT_EN] = s_q.channel_number_out_en;
      end
      `OFS_PIN_VALUE: begin
        // Real pin level, so a shorted output shows up
        rd[3:0] = s_q.sync_b; // RULE_12
      end
      `OFS_BIAS: begin
        rd[8:0] = s_q.bias;
      end
      `OFS_STATUS: begin
        rd[0] = s_q.code_seen;
        rd[1] = s_q.phase;
        rd[2] = chop_on;
        rd[3] = av.have_prev;
        rd[4] = s_q.first_pending;
        rd[5] = standby;
        // Sources on without reference is a software fault, flagged
        rd[6] = ((s_q.mag_a != EXC_OFF) || (s_q.mag_b != EXC_OFF)) && !s_q.ref_en; // RULE_07
        rd[9:8] = s_q.sw_closed;
      end
      `OFS_RESULT: begin
        rd[23:0] = s_q.code;
      end
      default: begin
        rd = 32'h00000000;
      end
    endcase
    if (psel && !penable) begin
      s_d.rdata = rd;
    end
  end

  // ==========================================
  // Registers
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '0;
      // Reference starts on so sources are safe from the start
      s_q.bipolar <= RST_MISC[`F_BIPOLAR];
      s_q.chop_field <= RST_MISC[`F_CHOP_HI:`F_CHOP_LO];
      s_q.exc_swap_enable <= RST_MISC[`F_EXC_SWAP];
      s_q.ref_en <= RST_MISC[`F_REF_EN];
      s_q.bias <= `RST_BIAS;
      s_q.first_pending <= 1'b1;
      s_q.pin_oe_n <= 4'hF;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================
  // Outputs
  // Every access completes in its first access cycle
  assign pready = 1'b1;
  // Writes to read-only words drop silently, no error
  assign pslverr = psel && penable && !mapped;
  assign prdata = s_q.rdata;
  // Chop doubles the wait only for the first polarity after a restart
  assign settle_double = chop_on && s_q.first_pending; // RULE_18
  assign rate_third = chop_on && sinc3_sel; // RULE_19
  assign in_swap = chop_on && s_q.phase; // RULE_17
  assign data_valid = s_q.valid_pulse;
  assign data_code = s_q.code;
  assign exc_pin_a = s_q.exc_a_pin;
  assign exc_mag_a = s_q.exc_a_mag;
  assign exc_pin_b = s_q.exc_b_pin;
  assign exc_mag_b = s_q.exc_b_mag;
  assign ref_en = s_q.ref_en;
  assign bridge_switch_closed = s_q.sw_closed;
  assign bias_input_enable = s_q.bias;
  assign gpio_out = s_q.pin_out;
  assign gpio_oe_n = s_q.pin_oe_n;
endmodule : aux_pin_and_chop_control

// ---- tb/aux_chk_sva.sv ----
`timescale 1ns/100ps
module aux_chk (
  input wire logic ref_clk, // Core clock
  input wire logic sys_rst, // Async reset
  input wire logic psel, // APB select
  input wire logic penable, // APB access
  input wire logic pwrite, // APB direction
  input wire logic conv_done, // Result pulse
  input wire logic sinc3_sel, // Sinc3 in use
  input wire logic in_swap, // Polarity inverted
  input wire logic settle_double, // Double settle due
  input wire logic rate_third, // Rate reduction
  input wire logic data_valid, // Result pulse
  input wire logic [23:0] data_code, // Result
  input wire logic [1:0] bridge_switch_closed, // Switches
  input wire logic [3:0] gpio_oe_n // Drive enables
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  // ==========================================
  // Pin and conversion relations
  sw_undriven_a: assert property ((bridge_switch_closed & ~gpio_oe_n[1:0]) == 2'h0)
    else $error("switch pin driven");
  rate_cause_a: assert property (rate_third |-> sinc3_sel)
    else $error("rate cut without sinc3");
  phase_rise_a: assert property ($rose(in_swap) |-> $past(conv_done))
    else $error("polarity flipped without conversion");
  phase_back_a: assert property (conv_done && in_swap |=> !in_swap)
    else $error("polarity not restored");
  settle_end_a: assert property ($fell(settle_double) |->
    $past(conv_done) || $past(psel && penable && pwrite))
    else $error("double settle ended early");
  first_drop_a: assert property (conv_done && settle_double |-> ##2 !data_valid)
    else $error("first chop result delivered");
  out_delay_a: assert property (data_valid |-> $past(conv_done, 2))
    else $error("result without conversion");
  code_hold_a: assert property (!data_valid |-> $stable(data_code))
    else $error("result changed without pulse");
endmodule : aux_chk

bind aux_pin_and_chop_control aux_chk chk_i (.ref_clk, .sys_rst, .psel, .penable, .pwrite,
  .conv_done, .sinc3_sel, .in_swap, .settle_double, .rate_third, .data_valid, .data_code,
  .bridge_switch_closed, .gpio_oe_n);

// ---- tb/core_model.sv ----
`timescale 1ns/100ps
module core_model (
  input wire logic ref_clk, // Core clock
  input wire logic sys_rst, // Async reset
  input wire logic run, // Convert continuously
  input wire logic signed [23:0] ain, // Differential input
  input wire logic signed [23:0] ofs, // Core offset error
  input wire logic in_swap, // Inputs inverted
  input wire logic [3:0] gpio_out, // Pin drive levels
  input wire logic [3:0] gpio_oe_n, // Pin drive enables
  input wire logic [3:0] ext_lvl, // External pull levels
  input wire logic [3:0] exc_pin_a, // Source A pin
  input wire logic [3:0] exc_pin_b, // Source B pin
  output logic conv_done, // Result pulse
  output logic [23:0] conv_raw, // Offset binary result
  output logic [3:0] seq_channel, // Active channel
  output logic [3:0] gpio_in // Pin levels
);
  logic [2:0] cnt;
  logic signed [23:0] mis;
  // Source mismatch error follows which pin carries source A
  assign mis = (exc_pin_a == exc_pin_b) ? 24'sd0 : (exc_pin_a < exc_pin_b) ? 24'sd16 : -24'sd16;
  // Undriven pins fall to the external pull
  assign gpio_in = (gpio_out & ~gpio_oe_n) | (ext_lvl & gpio_oe_n);
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt <= 3'h0;
      conv_done <= 1'b0;
      conv_raw <= 24'h0;
      seq_channel <= 4'h0;
    end else begin
      conv_done <= run && cnt == 3'h7;
      if (run) begin
        cnt <= cnt + 3'h1;
      end
      if (run && cnt == 3'h7) begin
        // Offset stays put while the input flips, so chopping cancels it
        conv_raw <= ((in_swap ? -ain : ain) + ofs + mis) ^ 24'h800000;
        seq_channel <= seq_channel + 4'h1;
      end
    end
  end
endmodule : core_model

// ---- tb/tb_top.sv ----
`timescale 1ns/100ps
`include "aux_params.svh"
module tb_top;
  import aux_pkg::*;
  logic ref_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, conv_done, sinc3_sel = 0, standby = 0, run = 0;
  logic in_swap, settle_double, rate_third, data_valid, ref_en;
  logic [23:0] conv_raw, data_code;
  logic signed [23:0] ain = 24'h0, ofs = 24'h0;
  logic [3:0] seq_channel, exc_pin_a, exc_pin_b, gpio_in, gpio_out, gpio_oe_n;
  logic [3:0] ext_lvl = 4'hA;
  exc_magnitude_t exc_mag_a, exc_mag_b;
  logic [1:0] bridge_switch_closed;
  logic [8:0] bias_input_enable;
  int num_errors = 0, num_checks = 0;
  always #20 ref_clk = ~ref_clk;
  aux_pin_and_chop_control uut (.ref_clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .conv_done, .conv_raw, .sinc3_sel, .standby,
    .seq_channel, .in_swap, .settle_double, .rate_third, .data_valid, .data_code,
    .exc_pin_a, .exc_mag_a, .exc_pin_b, .exc_mag_b, .ref_en, .bridge_switch_closed,
    .bias_input_enable, .gpio_in, .gpio_out, .gpio_oe_n);
  core_model far (.ref_clk, .sys_rst, .run, .ain, .ofs, .in_swap, .gpio_out, .gpio_oe_n,
    .ext_lvl, .exc_pin_a, .exc_pin_b, .conv_done, .conv_raw, .seq_channel, .gpio_in);
  // ==========================================
  // Shared tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) begin
      @(posedge ref_clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic look(input int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : look
  // Third pulse: the pair is wholly from the present input and mode
  task automatic expect_code(input string what, input logic [23:0] exp);
    int n;
    n = 0;
    repeat (3) begin
      @(posedge ref_clk);
      while (data_valid !== 1'b1 && n < 200) begin
        n++;
        @(posedge ref_clk);
      end
    end
    if (n >= 200) begin
      num_errors++;
      $display("wrong value %s expected pulse seen none", what);
      print_verdict();
    end
    chk(what, exp, data_code);
  endtask : expect_code
  // ==========================================
  // Scenarios
  task automatic t_reset();
    apb(1'b0, `OFS_SETUP_MISC, 32'h0);
    chk("setup", `RST_SETUP_MISC, rd);
    chk("ref_en", 1'b1, ref_en);
    chk("oe", 4'hF, gpio_oe_n);
    chk("mag", EXC_OFF, exc_mag_a);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped err", 1'b1, err);
    chk("unmapped data", 32'h0, rd);
    $display("reset test done");
  endtask : t_reset
  task automatic t_format();
    logic signed [23:0] v [3] = '{24'h800000, 24'h000000, 24'h7FFFFF};
    run <= 1'b1;
    for (int b = 0; b < 2; b++) begin
      apb(1'b1, `OFS_SETUP_MISC, 32'h10 | b);
      for (int i = 0; i < 3; i++) begin
        ain <= v[i];
        expect_code("code", b ? v[i] : v[i] ^ `MSB_FLIP);
      end
    end
    $display("format test done");
  endtask : t_format
  task automatic t_chop();
    sinc3_sel <= 1'b1;
    ofs <= 24'h000100;
    ain <= 24'h001234;
    for (int c = 0; c < 4; c++) begin
      run <= 1'b0;
      apb(1'b1, `OFS_SETUP_MISC, 32'h11 | (c << 1));
      look(2);
      chk("settle", c == 1, settle_double);
      chk("rate", c == 1, rate_third);
      @(posedge ref_clk);
      run <= 1'b1;
      expect_code("chop", c == 1 ? 24'h001234 : 24'h001334);
    end
    $display("chop test done");
  endtask : t_chop
  task automatic t_swap();
    logic seen;
    seen = 0;
    ofs <= 24'h0;
    for (int m = 1; m < 8; m++) begin
      apb(1'b1, `OFS_EXC_SOURCE, 32'h0502 | (m << 4) | ((8 - m) << 12));
      look(2);
      chk("mags", {m[2:0], 3'(8 - m)}, {exc_mag_a, exc_mag_b});
    end
    apb(1'b1, `OFS_SETUP_MISC, 32'h19);
    repeat (4) begin
      expect_code("swap avg", 24'h001234);
      chk("pair", 1'b1, {exc_pin_a, exc_pin_b} inside {8'h25, 8'h52});
      seen = seen | (exc_pin_a == 4'h5);
    end
    chk("swapped", 1'b1, seen);
    apb(1'b1, `OFS_EXC_SOURCE, 32'h7363);
    look(2);
    chk("shared pin", 8'h33, {exc_pin_a, exc_pin_b});
    apb(1'b1, `OFS_SETUP_MISC, 32'h11);
    $display("swap test done");
  endtask : t_swap
  task automatic t_pins();
    run <= 1'b0;
    apb(1'b1, `OFS_PIN_VALUE, 32'h4);
    apb(1'b1, `OFS_PIN_FUNC, 32'h1C);
    apb(1'b1, `OFS_BRIDGE_SW, 32'h1F);
    look(3);
    chk("closed", 2'h3, bridge_switch_closed);
    chk("oe", 4'h3, gpio_oe_n);
    chk("out", 2'h1, gpio_out[3:2]);
    apb(1'b0, `OFS_PIN_VALUE, 32'h0);
    chk("levels", 32'h6, rd);
    standby <= 1'b1;
    look(2);
    chk("standby", 2'h1, bridge_switch_closed);
    @(posedge ref_clk);
    standby <= 1'b0;
    apb(1'b1, `OFS_PIN_FUNC, 32'h10);
    look(2);
    chk("chan", seq_channel[3:2], gpio_out[3:2]);
    chk("chan oe", 4'h3, gpio_oe_n);
    apb(1'b1, `OFS_BIAS, 32'h1FF);
    look(2);
    chk("bias", 9'h1FF, bias_input_enable);
    $display("pin test done");
  endtask : t_pins
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_format();
    t_chop();
    t_swap();
    t_pins();
    print_verdict();
  end
  // Whole run needs well under a thousand cycles
  initial begin
    #(40 * 30000);
    num_errors++;
    print_verdict();
  end
endmodule : tb_top
